/* verilog/ist_pkg.sv */
// shared constants, types and cost arithmetic for instruction state timing
package ist_pkg;

  // widths
  localparam int IST_WAIT_W = 4;
  localparam int IST_CNT_W  = 4;
  localparam int IST_COST_W = 8;
  localparam int IST_ACC_W  = 12;
  localparam int IST_CLS_W  = 5;

  // state cost per cycle under each access condition
  localparam logic [7:0] COST_INTERNAL    = 8'h01;
  localparam logic [7:0] COST_ONCHIP_MEM  = 8'h02;
  localparam logic [7:0] COST_SUP8_WORD   = 8'h06;
  localparam logic [7:0] COST_SUP8_BYTE   = 8'h03;
  localparam logic [7:0] COST_SUP16       = 8'h03;
  localparam logic [7:0] COST_EXT8_2_WORD = 8'h04;
  localparam logic [7:0] COST_EXT8_2_BYTE = 8'h02;
  localparam logic [7:0] COST_EXT8_3_WORD = 8'h06;
  localparam logic [7:0] COST_EXT8_3_BYTE = 8'h03;
  localparam logic [7:0] WAIT_MUL_EXT8_W  = 8'h02;
  localparam logic [7:0] COST_EXT16_2     = 8'h02;
  localparam logic [7:0] COST_EXT16_3     = 8'h03;

  // cycle counts used in the profiles
  localparam logic [3:0] N_NONE  = 4'h0;
  localparam logic [3:0] N_ONE   = 4'h1;
  localparam logic [3:0] N_TWO   = 4'h2;
  localparam logic [3:0] N_THREE = 4'h3;

  // index of the last of the six cycle kinds walked per instruction
  localparam logic [2:0] IST_LAST_KIND = 3'h5;

  typedef enum logic [2:0] {
    IST_K_FETCH  = 3'h0,
    IST_K_BRADDR = 3'h1,
    IST_K_STACK  = 3'h2,
    IST_K_BYTE   = 3'h3,
    IST_K_WORD   = 3'h4,
    IST_K_INTERN = 3'h5
  } ist_kind_t;

  typedef enum logic [2:0] {
    IST_T_ONCHIP  = 3'h0,
    IST_T_SUP8    = 3'h1,
    IST_T_SUP16   = 3'h2,
    IST_T_EXT8_2  = 3'h3,
    IST_T_EXT8_3  = 3'h4,
    IST_T_EXT16_2 = 3'h5,
    IST_T_EXT16_3 = 3'h6
  } ist_tgt_t;

  typedef enum logic [4:0] {
    IST_C_ADD_B_IMM  = 5'h00,
    IST_C_ADD_B_REG  = 5'h01,
    IST_C_ADD_W_IMM  = 5'h02,
    IST_C_ADD_W_REG  = 5'h03,
    IST_C_ADD_L_IMM  = 5'h04,
    IST_C_ADD_L_REG  = 5'h05,
    IST_C_ADD_PTR    = 5'h06,
    IST_C_ADDC_IMM   = 5'h07,
    IST_C_ADDC_REG   = 5'h08,
    IST_C_AND_B_IMM  = 5'h09,
    IST_C_AND_B_REG  = 5'h0A,
    IST_C_AND_W_IMM  = 5'h0B,
    IST_C_AND_W_REG  = 5'h0C,
    IST_C_AND_L_IMM  = 5'h0D,
    IST_C_AND_L_REG  = 5'h0E,
    IST_C_FLAG_AND   = 5'h0F,
    IST_C_BAND_REG   = 5'h10,
    IST_C_BAND_IND   = 5'h11,
    IST_C_BAND_ABS   = 5'h12,
    IST_C_BRANCH8    = 5'h13
  } ist_cls_t;

  typedef struct packed {
    logic [3:0] i;
    logic [3:0] j;
    logic [3:0] k;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] n;
  } ist_prof_t;

  // count of one cycle kind out of a profile
  function automatic logic [3:0] ist_pick(ist_prof_t p, ist_kind_t k);
    case (k)
      IST_K_FETCH:  ist_pick = p.i;
      IST_K_BRADDR: ist_pick = p.j;
      IST_K_STACK:  ist_pick = p.k;
      IST_K_BYTE:   ist_pick = p.l;
      IST_K_WORD:   ist_pick = p.m;
      default:      ist_pick = p.n;
    endcase
  endfunction

  // states charged for one cycle of kind k to target t with w wait states
  function automatic logic [7:0] ist_cost(ist_kind_t k, ist_tgt_t t, logic [3:0] w);
    logic       is_byte;
    logic [7:0] w8;
    is_byte = (k == IST_K_BYTE);
    w8      = {4'h0, w};
    if (k == IST_K_INTERN) begin
      ist_cost = COST_INTERNAL;
    end else begin
      // address read and stack cycles cost as fetch or word access
      case (t)
        IST_T_ONCHIP:  ist_cost = COST_ONCHIP_MEM;
        IST_T_SUP8:    ist_cost = is_byte ? COST_SUP8_BYTE : COST_SUP8_WORD;
        IST_T_SUP16:   ist_cost = COST_SUP16;
        IST_T_EXT8_2:  ist_cost = is_byte ? COST_EXT8_2_BYTE : COST_EXT8_2_WORD;
        IST_T_EXT8_3:  ist_cost = is_byte ? 8'(COST_EXT8_3_BYTE + w8)
                                          : 8'(COST_EXT8_3_WORD + WAIT_MUL_EXT8_W * w8);
        IST_T_EXT16_2: ist_cost = COST_EXT16_2;
        IST_T_EXT16_3: ist_cost = 8'(COST_EXT16_3 + w8);
        default:       ist_cost = COST_ONCHIP_MEM;
      endcase
    end
  endfunction

endpackage

/* verilog/ist_prof_if.sv */
// carrier between the timing sequencer and its profile decoder
`timescale 1ns/10ps
`default_nettype none
interface ist_prof_if;
  import ist_pkg::*;
  logic      load;
  ist_cls_t  cls;
  ist_prof_t prof;
  logic      known;
  modport req (output load, output cls, input prof, input known);
  modport rsp (input load, input cls, output prof, output known);
endinterface
`default_nettype wire

/* verilog/ist_profile.sv */
// cycle profile decoder, registered on load
`timescale 1ns/10ps
`default_nettype none
module ist_profile
  import ist_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  ist_prof_if.rsp     pif
);

  ist_prof_t prof_nxt;
  logic      known_nxt;

  // fixed profile per instruction class
  always_comb begin
    prof_nxt  = '{N_NONE, N_NONE, N_NONE, N_NONE, N_NONE, N_NONE};
    known_nxt = 1'b1;
    case (pif.cls)
      IST_C_ADD_B_IMM, IST_C_ADD_B_REG, IST_C_ADD_W_REG,
      IST_C_ADD_L_REG, IST_C_ADD_PTR, IST_C_ADDC_IMM, IST_C_ADDC_REG,
      IST_C_AND_B_IMM, IST_C_AND_B_REG, IST_C_AND_W_REG,
      IST_C_FLAG_AND: begin
        prof_nxt.i = N_ONE;
      end
      IST_C_ADD_W_IMM, IST_C_AND_W_IMM, IST_C_AND_L_REG: begin
        prof_nxt.i = N_TWO;
      end
      IST_C_ADD_L_IMM, IST_C_AND_L_IMM: begin
        prof_nxt.i = N_THREE;
      end
      IST_C_BAND_REG: begin
        prof_nxt.i = N_ONE;
      end
      IST_C_BAND_IND, IST_C_BAND_ABS: begin
        prof_nxt.i = N_TWO;
        prof_nxt.l = N_ONE;
      end
      IST_C_BRANCH8: begin
        // taken or not, the cost is the same
        prof_nxt.i = N_TWO;
      end
      default: begin
        known_nxt = 1'b0;
      end
    endcase
  end

  // hold the profile for the whole walk
  always_ff @(posedge clk) begin
    if (rst) begin
      pif.prof  <= '0;
      pif.known <= 1'b0;
    end else if (pif.load) begin
      pif.prof  <= prof_nxt;
      pif.known <= known_nxt;
    end
  end

endmodule
`default_nettype wire

/* verilog/ist_timing.sv */
// instruction state timing: walks a cycle profile and sums state costs
`timescale 1ns/10ps
`default_nettype none
// Contract
// - on-chip memory 2, internal operation 1
// - supporting modules: 8-bit 6/3, 16-bit 3
// - external 8-bit: 4/2, or 6+2m/3+m
// - external 16-bit: 2, or 3+m
// - each wait state lengthens three-state external access
// - instruction is fixed six-kind cycle profile
// - total is sum of count times cost
// - add forms take one, two, three fetches
// - bit-and memory form: two fetches, one byte
// - short branch always two fetches only
module ist_timing
  import ist_pkg::*;
(
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  input  wire logic                  START,
  input  wire logic [IST_CLS_W-1:0]  INSTR_CLASS,
  input  wire logic [2:0]            FETCH_TGT,
  input  wire logic [2:0]            BRADDR_TGT,
  input  wire logic [2:0]            STACK_TGT,
  input  wire logic [2:0]            DATA_TGT,
  input  wire logic [IST_WAIT_W-1:0] WAIT_STATES,
  output logic                       BUSY,
  output logic                       DONE,
  output logic [IST_ACC_W-1:0]       STATES,
  output logic                       UNKNOWN_CLASS
);

  typedef enum logic [1:0] {
    IST_S_IDLE = 2'b00,
    IST_S_SUM  = 2'b01
  } ist_state_t;

  ist_state_t            state_r;
  ist_kind_t             kind_r;
  ist_tgt_t              fetch_tgt_r;
  ist_tgt_t              braddr_tgt_r;
  ist_tgt_t              stack_tgt_r;
  ist_tgt_t              data_tgt_r;
  logic [IST_WAIT_W-1:0] wait_r;
  logic [IST_ACC_W-1:0]  acc_r;
  logic [IST_ACC_W-1:0]  acc_nxt;
  logic [IST_ACC_W-1:0]  term;
  logic [IST_COST_W-1:0] cost;
  ist_tgt_t              tgt;
  logic                  take;
  logic                  last;

  ist_prof_if pif ();

  ist_profile u_profile (
    .clk (CLOCK),
    .rst (RST),
    .pif (pif)
  );

  // a request is taken only while idle; starts during a walk are dropped
  assign take     = START && (state_r == IST_S_IDLE);
  assign last     = (kind_r == ist_kind_t'(IST_LAST_KIND));
  assign pif.load = take;
  assign pif.cls  = ist_cls_t'(INSTR_CLASS);

  // target of the cycle kind under way
  always_comb begin
    case (kind_r)
      IST_K_FETCH:  tgt = fetch_tgt_r;
      IST_K_BRADDR: tgt = braddr_tgt_r;
      IST_K_STACK:  tgt = stack_tgt_r;
      default:      tgt = data_tgt_r;
    endcase
  end

  // one kind per clock: count times cost, added to the running total
  assign cost    = ist_cost(kind_r, tgt, wait_r);
  assign term    = IST_ACC_W'(ist_pick(pif.prof, kind_r) * cost);
  assign acc_nxt = IST_ACC_W'(acc_r + term);

  // access conditions are frozen at start so a mid-walk change cannot skew the sum
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fetch_tgt_r  <= IST_T_ONCHIP;
      braddr_tgt_r <= IST_T_ONCHIP;
      stack_tgt_r  <= IST_T_ONCHIP;
      data_tgt_r   <= IST_T_ONCHIP;
      wait_r       <= '0;
    end else if (take) begin
      fetch_tgt_r  <= ist_tgt_t'(FETCH_TGT);
      braddr_tgt_r <= ist_tgt_t'(BRADDR_TGT);
      stack_tgt_r  <= ist_tgt_t'(STACK_TGT);
      data_tgt_r   <= ist_tgt_t'(DATA_TGT);
      wait_r       <= WAIT_STATES;
    end
  end

  // walk all six kinds in fixed order
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_r <= IST_S_IDLE;
      kind_r  <= IST_K_FETCH;
      acc_r   <= '0;
    end else begin
      case (state_r)
        IST_S_IDLE: begin
          if (take) begin
            state_r <= IST_S_SUM;
            kind_r  <= IST_K_FETCH;
            acc_r   <= '0;
          end
        end
        IST_S_SUM: begin
          acc_r <= acc_nxt;
          if (last) begin
            state_r <= IST_S_IDLE;
          end else begin
            kind_r <= ist_kind_t'(kind_r + 3'h1);
          end
        end
        default: begin
          state_r <= IST_S_IDLE;
        end
      endcase
    end
  end

  // result outputs, all registered
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      BUSY          <= 1'b0;
      DONE          <= 1'b0;
      STATES        <= '0;
      UNKNOWN_CLASS <= 1'b0;
    end else begin
      DONE <= 1'b0;
      if (take) begin
        BUSY <= 1'b1;
      end else if (state_r == IST_S_SUM && last) begin
        BUSY          <= 1'b0;
        DONE          <= 1'b1;
        STATES        <= acc_nxt;
        UNKNOWN_CLASS <= !pif.known;
      end
    end
  end

  // helper: whole sum in one shot, checked against the walked result
  logic [IST_ACC_W-1:0] expect_r;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      expect_r <= '0;
    end else if (state_r == IST_S_SUM && kind_r == IST_K_FETCH) begin
      expect_r <= IST_ACC_W'(
        pif.prof.i * ist_cost(IST_K_FETCH, fetch_tgt_r, wait_r)
        + pif.prof.j * ist_cost(IST_K_BRADDR, braddr_tgt_r, wait_r)
        + pif.prof.k * ist_cost(IST_K_STACK, stack_tgt_r, wait_r)
        + pif.prof.l * ist_cost(IST_K_BYTE, data_tgt_r, wait_r)
        + pif.prof.m * ist_cost(IST_K_WORD, data_tgt_r, wait_r)
        + pif.prof.n * ist_cost(IST_K_INTERN, data_tgt_r, wait_r));
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence walk_s;
    BUSY [*6];
  endsequence

  sequence finish_s;
    !BUSY && DONE;
  endsequence

  walk_length_a: assert property (take |=> walk_s ##1 finish_s)
    else $error("walk did not finish after six kinds");
  sum_total_a: assert property ($rose(DONE) |-> STATES == expect_r)
    else $error("total differs from sum of count times cost");
  onchip_cost_a: assert property (state_r == IST_S_SUM && tgt == IST_T_ONCHIP
      && kind_r != IST_K_INTERN |-> cost == 8'h02)
    else $error("on-chip cycle not two states");
  intern_cost_a: assert property (state_r == IST_S_SUM && kind_r == IST_K_INTERN
      |-> cost == 8'h01)
    else $error("internal cycle not one state");
  sup8_cost_a: assert property (state_r == IST_S_SUM && tgt == IST_T_SUP8
      && kind_r != IST_K_INTERN |-> cost == ((kind_r == IST_K_BYTE) ? 8'h03 : 8'h06))
    else $error("supporting 8-bit cost wrong");
  sup16_cost_a: assert property (state_r == IST_S_SUM && tgt == IST_T_SUP16
      && kind_r == IST_K_FETCH |-> cost == 8'h03)
    else $error("supporting 16-bit fetch cost wrong");
  ext8_fast_a: assert property (state_r == IST_S_SUM && tgt == IST_T_EXT8_2
      && kind_r != IST_K_INTERN |-> cost == ((kind_r == IST_K_BYTE) ? 8'h02 : 8'h04))
    else $error("external 8-bit two-state cost wrong");
  ext8_wait_a: assert property (state_r == IST_S_SUM && tgt == IST_T_EXT8_3
      && kind_r == IST_K_WORD |-> cost == 8'(8'h06 + 2 * wait_r))
    else $error("external 8-bit three-state word cost wrong");
  ext16_wait_a: assert property (state_r == IST_S_SUM && tgt == IST_T_EXT16_3
      && kind_r != IST_K_INTERN |-> cost == 8'(8'h03 + wait_r))
    else $error("external 16-bit three-state cost wrong");
  ext16_fast_a: assert property (state_r == IST_S_SUM && tgt == IST_T_EXT16_2
      && kind_r == IST_K_FETCH |-> cost == 8'h02)
    else $error("external 16-bit two-state fetch cost wrong");
  stack_like_a: assert property (state_r == IST_S_SUM && kind_r == IST_K_STACK
      |-> cost == ist_cost(IST_K_FETCH, stack_tgt_r, wait_r))
    else $error("stack cycle cost differs from fetch");
  branch_prof_a: assert property (take && pif.cls == IST_C_BRANCH8
      |=> pif.prof == {4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0})
    else $error("short branch profile wrong");
  band_prof_a: assert property (take && pif.cls == IST_C_BAND_IND
      |=> pif.prof.i == 4'h2 && pif.prof.l == 4'h1)
    else $error("bit-and memory profile wrong");
  long_add_a: assert property (take && pif.cls == IST_C_ADD_L_IMM
      |=> pif.prof.i == 4'h3 && pif.prof.l == 4'h0)
    else $error("long immediate add profile wrong");
  wait_grows_a: assert property (state_r == IST_S_SUM && tgt == IST_T_EXT8_3
      && kind_r == IST_K_BYTE |-> cost == 8'(8'h03 + wait_r))
    else $error("byte access does not grow by one per wait");

endmodule
`default_nettype wire

/* dv/ist_bus_model.sv */
// behavioural model of the bus targets: states charged per access
`timescale 1ns/10ps
`default_nettype none
module ist_bus_model;
  // kinds: 0 fetch, 1 address read, 2 stack, 3 byte, 4 word, 5 internal
  // targets follow the design code; 7 is taken as on-chip memory
  function automatic int cost(input int k, input int t, input int m);
    bit b;
    b = (k == 3);
    if (k == 5) return 1;
    // only byte cycles differ, so address read and stack fall in with fetch
    case (t)
      1:       return b ? 3 : 6;
      2:       return 3;
      3:       return b ? 2 : 4;
      4:       return b ? 3 + m : 6 + 2 * m;
      5:       return 2;
      6:       return 3 + m;
      default: return 2;
    endcase
  endfunction
endmodule
`default_nettype wire

/* dv/tb_instr_state_timing.sv */
// self-checking bench for the instruction state timing block
`timescale 1ns/10ps
`default_nettype none
module tb_instr_state_timing;
  import ist_pkg::*;
  logic                  clock;
  logic                  rst;
  logic                  start;
  logic [IST_CLS_W-1:0]  cls;
  logic [2:0]            ft;
  logic [2:0]            bt;
  logic [2:0]            st;
  logic [2:0]            dt;
  logic [IST_WAIT_W-1:0] waits;
  logic                  busy;
  logic                  done;
  logic [IST_ACC_W-1:0]  states;
  logic                  unk;
  int                    failures;
  int                    samples_checked;
  int                    seed;
  int                    i;
  int                    t;
  logic [11:0]           exp_q[$];

  ist_timing dut_u (
    .CLOCK         (clock),
    .RST           (rst),
    .START         (start),
    .INSTR_CLASS   (cls),
    .FETCH_TGT     (ft),
    .BRADDR_TGT    (bt),
    .STACK_TGT     (st),
    .DATA_TGT      (dt),
    .WAIT_STATES   (waits),
    .BUSY          (busy),
    .DONE          (done),
    .STATES        (states),
    .UNKNOWN_CLASS (unk)
  );

  ist_bus_model bus_u ();

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // fetch cycles per class; codes past 13h decode to nothing
  function automatic int fetches(input int c);
    case (c)
      2, 11, 14, 17, 18, 19: return 2;
      4, 13:                 return 3;
      default:               return (c < 20) ? 1 : 0;
    endcase
  endfunction

  // byte data cycles: only the memory bit-and forms touch data
  function automatic int bytes_of(input int c);
    return (c == 17 || c == 18) ? 1 : 0;
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one instruction; refuse pokes START mid-run with junk that must be ignored
  task automatic run_one(input logic [4:0] c, input logic [2:0] f, input logic [2:0] d,
                         input logic [3:0] m, input bit refuse);
    int          k;
    logic [11:0] ex;
    exp_q.push_back(12'(fetches(c) * bus_u.cost(0, f, m) + bytes_of(c) * bus_u.cost(3, d, m)));
    @(posedge clock);
    start <= 1'b1;
    cls   <= c;
    ft    <= f;
    dt    <= d;
    waits <= m;
    bt    <= 3'($random(seed));
    st    <= 3'($random(seed));
    @(posedge clock);
    start <= 1'b0;
    for (k = 1; k <= 20; k++) begin
      @(negedge clock);
      if (done === 1'b1) break;
      chk({11'h000, busy}, 12'h001);
      @(posedge clock);
      if (refuse && k == 1) begin
        start <= 1'b1;
        cls   <= 5'($random(seed));
        dt    <= 3'($random(seed));
        waits <= 4'($random(seed));
      end
      if (k == 2) start <= 1'b0;
    end
    if (k > 20) begin
      failures++;
      tally_and_finish;
    end
    ex = exp_q.pop_front();
    chk(12'(k), 12'h007);
    chk(states, ex);
    chk({11'h000, unk}, {11'h000, (c > 5'h13)});
    @(negedge clock);
    chk({11'h000, done}, 12'h000);
    chk(states, ex);
  endtask

  initial begin
    seed            = 32'hD532;
    failures        = 0;
    samples_checked = 0;
    rst             = 1'b1;
    start           = 1'b0;
    cls             = 5'h00;
    ft              = 3'h0;
    bt              = 3'h0;
    st              = 3'h0;
    dt              = 3'h0;
    waits           = 4'h0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk({states[9:0], busy, done}, 12'h000);
    // worked example: 3-state external fetch with one wait, 8-bit module byte
    run_one(5'h11, 3'h4, 3'h1, 4'h1, 1'b0);
    chk(states, 12'h013);
    $display("test example done");
    // every class against every target, with the data target mirrored
    for (i = 0; i < 22; i++) begin
      for (t = 0; t < 8; t++) begin
        run_one(5'(i < 20 ? i : (i == 20 ? 20 : 31)), 3'(t), 3'(7 - t),
                4'($random(seed)), 1'b0);
      end
    end
    $display("test sweep done");
    // random traffic with ignored requests while busy
    for (i = 0; i < 150; i++) begin
      run_one(5'($random(seed)), 3'($random(seed)), 3'($random(seed)),
              4'($random(seed)), 1'b1);
    end
    $display("test random done");
    // reset lands in the middle of a sum, then the block must recover
    @(posedge clock);
    start <= 1'b1;
    cls   <= 5'h04;
    @(posedge clock);
    start <= 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk({states[9:0], busy, done}, 12'h000);
    chk({11'h000, unk}, 12'h000);
    run_one(5'h04, 3'h6, 3'h0, 4'hF, 1'b0);
    $display("test reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
